/* File: design/uart_line_modem_status.sv */
// Line status and modem status logic of one UART channel, with Avalon-MM slave.
// Assumes the receive FIFO, transmitter and interrupt logic of the channel sit
// outside and that all inputs are synchronous to SYS_CLK.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - The parity error flag is set for a character with bad parity, and in FIFO mode it follows the character at the top of the receive FIFO.
// - A character arriving while the receive FIFO is full sets the overrun flag and replaces the shift register contents.
// - During an overrun the shift register byte is not pushed, so the FIFO contents stay intact.
// - Data ready is 1 while any received character is held and 0 when none remains.
// - Parity, overrun, data ready and modem change flags rest at 0 while no event is pending.
// - Four change bits in the modem status register: three set on any change of their modem input, the ring bit on its 0 to 1 change only.
// - Reading the modem status register clears the change bits that the read reports.
// - Bit 7 is the inverted carrier detect input, or the second user output bit in loop-back.
// - Bit 6 is the inverted ring input, or the first user output bit in loop-back.
// - Bit 5 is the inverted data set ready input, or the DTR bit in loop-back.
// - Bit 4 is the inverted CTS input, or the RTS bit in loop-back.
// - With automatic CTS enabled and CTS high, transmission halts once the current character ends.
// - The carrier detect change bit sets on any change since the last read and raises a modem interrupt.
// - The ring change bit sets only when the ring input goes from 0 to 1 and raises a modem interrupt.
// - The DSR and CTS change bits set on any change, and any set change bit raises a modem interrupt.
module uart_line_modem_status (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  input  wire logic        FIFO_MODE,
  input  wire logic        RX_CHAR_DONE,
  input  wire logic        RX_CHAR_PARITY_ERR,
  input  wire logic        RX_FIFO_FULL,
  input  wire logic        RX_FIFO_EMPTY,
  input  wire logic        RX_TOP_PARITY_ERR,
  output var  logic        RX_PUSH,
  input  wire logic        TX_CHAR_DONE,
  input  wire logic        TX_IDLE,
  output var  logic        TX_HALT,
  input  wire logic        CTS_N,
  input  wire logic        DSR_N,
  input  wire logic        RI_N,
  input  wire logic        CD_N,
  output var  logic        DTR_N,
  output var  logic        RTS_N,
  output var  logic        USER_OUTPUT_FIRST_N,
  output var  logic        USER_OUTPUT_SECOND_N,
  output var  logic        LOOPBACK,
  output var  logic        MODEM_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] modem_output_control;
  logic [7:0] feature_extension_control;
  logic       data_ready;
  logic       overrun;
  logic       parity_err;
  logic [3:0] modem_state;
  logic [3:0] modem_prev;
  logic [3:0] modem_delta;
  logic       prev_valid;
  logic [3:0] next_modem_state;
  logic [3:0] delta_event;
  logic [7:0] line_condition;
  logic [7:0] modem_input_condition;
  logic       accept;
  logic       wr_accept;
  logic       rd_accept;
  logic       wr_low_lane;
  logic       loopback_on;
  logic       parity_event;
  logic       overrun_event;
  logic       cts_stop;
  logic       tx_busy_char;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the request is taken
  assign accept      = !AVS_WAITREQUEST && (AVS_READ || AVS_WRITE);
  assign wr_accept   = accept && AVS_WRITE;
  assign rd_accept   = accept && AVS_READ;
  assign wr_low_lane = wr_accept && AVS_BYTEENABLE[0];

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)) begin
      AVS_WAITREQUEST <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Read data is captured during the wait cycle and stands at the taking edge
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      AVS_READDATA <= uart_status_pkg::READ_DATA_RST;
    end else if (AVS_WAITREQUEST && AVS_READ) begin
      case (AVS_ADDRESS)
        uart_status_pkg::LINE_CONDITION_OFS: begin
          AVS_READDATA <= {24'h00_0000, line_condition};
        end
        uart_status_pkg::MODEM_INPUT_CONDITION_OFS: begin
          AVS_READDATA <= {24'h00_0000, modem_input_condition};
        end
        uart_status_pkg::MODEM_OUTPUT_CONTROL_OFS: begin
          AVS_READDATA <= {24'h00_0000, modem_output_control};
        end
        uart_status_pkg::FEATURE_EXT_CONTROL_OFS: begin
          AVS_READDATA <= {24'h00_0000, feature_extension_control};
        end
        default: begin
          AVS_READDATA <= uart_status_pkg::READ_DATA_RST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable control registers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      modem_output_control <= uart_status_pkg::MODEM_OUTPUT_CONTROL_RST;
    end else if (wr_low_lane &&
                 AVS_ADDRESS == uart_status_pkg::MODEM_OUTPUT_CONTROL_OFS) begin
      modem_output_control <= {3'h0, AVS_WRITEDATA[4:0]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      feature_extension_control <= uart_status_pkg::FEATURE_EXT_CONTROL_RST;
    end else if (wr_low_lane &&
                 AVS_ADDRESS == uart_status_pkg::FEATURE_EXT_CONTROL_OFS) begin
      feature_extension_control <= {AVS_WRITEDATA[7], 7'h00};
    end
  end

  assign loopback_on = modem_output_control[uart_status_pkg::MO_LOOPBACK];

  // Outputs go inactive while looped back so the far end sees no activity
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      DTR_N                <= 1'b1;
      RTS_N                <= 1'b1;
      USER_OUTPUT_FIRST_N  <= 1'b1;
      USER_OUTPUT_SECOND_N <= 1'b1;
      LOOPBACK             <= 1'b0;
    end else begin
      DTR_N <= loopback_on ||
               !modem_output_control[uart_status_pkg::MO_DTR];
      RTS_N <= loopback_on ||
               !modem_output_control[uart_status_pkg::MO_RTS];
      USER_OUTPUT_FIRST_N <= loopback_on ||
               !modem_output_control[uart_status_pkg::MO_USER_FIRST];
      USER_OUTPUT_SECOND_N <= loopback_on ||
               !modem_output_control[uart_status_pkg::MO_USER_SECOND];
      LOOPBACK <= loopback_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive line status
  assign parity_event  = FIFO_MODE ? (RX_TOP_PARITY_ERR && !RX_FIFO_EMPTY)
                                   : (RX_CHAR_DONE && RX_CHAR_PARITY_ERR);
  assign overrun_event = RX_CHAR_DONE && RX_FIFO_FULL;

  // Full FIFO blocks the push of the overwritten shift register byte
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      RX_PUSH <= 1'b0;
    end else begin
      RX_PUSH <= RX_CHAR_DONE && !RX_FIFO_FULL;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= !RX_FIFO_EMPTY;
    end
  end

  // Only bits reported by the read are cleared; a new event always wins
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      overrun <= 1'b0;
    end else if (overrun_event) begin
      overrun <= 1'b1;
    end else if (rd_accept &&
                 AVS_ADDRESS == uart_status_pkg::LINE_CONDITION_OFS &&
                 AVS_READDATA[uart_status_pkg::LC_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      parity_err <= 1'b0;
    end else if (parity_event) begin
      parity_err <= 1'b1;
    end else if (rd_accept &&
                 AVS_ADDRESS == uart_status_pkg::LINE_CONDITION_OFS &&
                 AVS_READDATA[uart_status_pkg::LC_PARITY_ERR]) begin
      parity_err <= 1'b0;
    end
  end

  always_comb begin
    line_condition = uart_status_pkg::STATUS_RST;
    line_condition[uart_status_pkg::LC_DATA_READY] = data_ready;
    line_condition[uart_status_pkg::LC_OVERRUN]    = overrun;
    line_condition[uart_status_pkg::LC_PARITY_ERR] = parity_err;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem input state, order CTS, DSR, RI, CD from bit 4 upward
  always_comb begin
    if (loopback_on) begin
      next_modem_state[0] = modem_output_control[uart_status_pkg::MO_RTS];
      next_modem_state[1] = modem_output_control[uart_status_pkg::MO_DTR];
      next_modem_state[2] = modem_output_control[uart_status_pkg::MO_USER_FIRST];
      next_modem_state[3] = modem_output_control[uart_status_pkg::MO_USER_SECOND];
    end else begin
      next_modem_state[0] = !CTS_N;
      next_modem_state[1] = !DSR_N;
      next_modem_state[2] = !RI_N;
      next_modem_state[3] = !CD_N;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      modem_state <= 4'h0;
      modem_prev  <= 4'h0;
      prev_valid  <= 1'b0;
    end else begin
      modem_state <= next_modem_state;
      modem_prev  <= modem_state;
      prev_valid  <= 1'b1;
    end
  end

  // Change bits; ring only on its input rising, i.e. the status bit falling
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_delta
      if (i == uart_status_pkg::MI_RI_DELTA) begin : g_edge
        assign delta_event[i] = prev_valid && modem_prev[i] && !modem_state[i];
      end else begin : g_any
        assign delta_event[i] = prev_valid && (modem_prev[i] != modem_state[i]);
      end

      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          modem_delta[i] <= 1'b0;
        end else if (delta_event[i]) begin
          modem_delta[i] <= 1'b1;
        end else if (rd_accept &&
                     AVS_ADDRESS == uart_status_pkg::MODEM_INPUT_CONDITION_OFS &&
                     AVS_READDATA[uart_status_pkg::MI_DELTA_LO + i]) begin
          modem_delta[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign modem_input_condition = {modem_state, modem_delta};

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      MODEM_IRQ <= 1'b0;
    end else begin
      MODEM_IRQ <= |modem_delta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Automatic CTS gating of the transmitter
  assign cts_stop = feature_extension_control[uart_status_pkg::FE_AUTO_CTS] &&
                    !modem_state[0];
  assign tx_busy_char = !TX_IDLE && !TX_CHAR_DONE;

  // Halt is raised only between characters, so a running character completes
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      TX_HALT <= 1'b0;
    end else if (!cts_stop) begin
      TX_HALT <= 1'b0;
    end else if (!tx_busy_char) begin
      TX_HALT <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: design/uart_status_pkg.sv */
// Constants for the line and modem status block of one UART channel.
// Assumes a 32-bit register bus with byte addresses and one register per word.
package uart_status_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [3:0] LINE_CONDITION_OFS        = 4'h0;
  localparam logic [3:0] MODEM_INPUT_CONDITION_OFS = 4'h4;
  localparam logic [3:0] MODEM_OUTPUT_CONTROL_OFS  = 4'h8;
  localparam logic [3:0] FEATURE_EXT_CONTROL_OFS   = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int LC_DATA_READY   = 0;
  localparam int LC_OVERRUN      = 1;
  localparam int LC_PARITY_ERR   = 2;
  localparam int MI_DELTA_LO     = 0;
  localparam int MI_RI_DELTA     = 2;
  localparam int MI_STATE_LO     = 4;
  localparam int MO_DTR          = 0;
  localparam int MO_RTS          = 1;
  localparam int MO_USER_FIRST   = 2;
  localparam int MO_USER_SECOND  = 3;
  localparam int MO_LOOPBACK     = 4;
  localparam int FE_AUTO_CTS     = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  MODEM_OUTPUT_CONTROL_RST = 8'h00;
  localparam logic [7:0]  FEATURE_EXT_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  STATUS_RST               = 8'h00;
  localparam logic [31:0] READ_DATA_RST            = 32'h0000_0000;

endpackage

/* File: sim/uart_status_sva.sv */
// Checker for the line and modem status block, bound to its top module.
// Sees only the top ports; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module uart_status_sva (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        RX_CHAR_DONE,
  input wire logic        RX_FIFO_FULL,
  input wire logic        RX_FIFO_EMPTY,
  input wire logic        RX_PUSH,
  input wire logic        TX_CHAR_DONE,
  input wire logic        TX_IDLE,
  input wire logic        TX_HALT,
  input wire logic        CTS_N,
  input wire logic        DSR_N,
  input wire logic        RI_N,
  input wire logic        CD_N,
  input wire logic        LOOPBACK,
  input wire logic        MODEM_IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic taken;
  assign taken = AVS_READ && !AVS_WAITREQUEST;
  a_wait_one_cycle: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_read_upper_zero: assert property (taken |-> AVS_READDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_push_when_room: assert property (RX_CHAR_DONE && !RX_FIFO_FULL |=> RX_PUSH)
    else $error("character not pushed");
  a_overrun_no_push: assert property (RX_CHAR_DONE && RX_FIFO_FULL |=> !RX_PUSH)
    else $error("push into full buffer");
  a_ready_follows: assert property (taken && AVS_ADDRESS == uart_status_pkg::LINE_CONDITION_OFS
    |-> AVS_READDATA[0] == !$past(RX_FIFO_EMPTY, 2)) else $error("data ready wrong");
  a_status_mirror: assert property (taken && AVS_ADDRESS == uart_status_pkg::MODEM_INPUT_CONDITION_OFS
    && !LOOPBACK && !$past(LOOPBACK, 3) |-> AVS_READDATA[7:4] == ~$past({CD_N, RI_N, DSR_N, CTS_N}, 2))
    else $error("modem state bits wrong");
  a_change_irq: assert property (($changed({CD_N, DSR_N, CTS_N}) || $rose(RI_N)) && !LOOPBACK
    |-> ##[1:4] MODEM_IRQ) else $error("no modem interrupt after change");
  a_halt_needs_cts: assert property (TX_HALT |-> $past(CTS_N, 2))
    else $error("halt without stop request");
  a_halt_at_boundary: assert property ($rose(TX_HALT) |-> $past(TX_IDLE || TX_CHAR_DONE))
    else $error("halt in mid character");
  cover property (taken && AVS_ADDRESS == uart_status_pkg::MODEM_INPUT_CONDITION_OFS && AVS_READDATA[3:0] != 4'h0);
  cover property (RX_CHAR_DONE && RX_FIFO_FULL);
  cover property ($rose(TX_HALT));
endmodule
`default_nettype wire

/* File: sim/modem_peer.sv */
// Behavioural modem driving the four active-low control lines {cd, ri, dsr, cts}.
// Assumes the bench picks the asserted lines; slow adds one cycle of lag.
`timescale 1ns/100ps
`default_nettype none
module modem_peer (
  input  wire logic       clk,
  input  wire logic [3:0] active,
  input  wire logic       slow,
  output var  logic [3:0] lines_n
);
  logic [3:0] lag = 4'hF;
  initial lines_n = 4'hF;
  always @(posedge clk) begin
    lag <= ~active;
    lines_n <= slow ? lag : ~active;
  end
endmodule
`default_nettype wire

/* File: sim/tb_uart_line_modem_status.sv */
// Self-checking bench for the line and modem status block.
// Assumes the package, design, checker and modem model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_uart_line_modem_status;
  localparam logic [3:0] lc = uart_status_pkg::LINE_CONDITION_OFS;
  localparam logic [3:0] mi = uart_status_pkg::MODEM_INPUT_CONDITION_OFS;
  localparam logic [3:0] mo = uart_status_pkg::MODEM_OUTPUT_CONTROL_OFS;
  localparam logic [3:0] fe = uart_status_pkg::FEATURE_EXT_CONTROL_OFS;
  logic        SYS_CLK, SRST, AVS_READ, AVS_WRITE, FIFO_MODE, RX_CHAR_DONE, RX_CHAR_PARITY_ERR;
  logic        RX_FIFO_FULL, RX_FIFO_EMPTY, RX_TOP_PARITY_ERR, TX_CHAR_DONE, TX_IDLE, slow;
  logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE, active;
  logic [31:0] AVS_WRITEDATA, rd;
  wire  logic [31:0] AVS_READDATA;
  wire  logic  AVS_WAITREQUEST, RX_PUSH, TX_HALT, DTR_N, RTS_N, USER_OUTPUT_FIRST_N, LOOPBACK;
  wire  logic  USER_OUTPUT_SECOND_N, MODEM_IRQ, CTS_N, DSR_N, RI_N, CD_N;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, i;

  uart_line_modem_status uut (.*);
  modem_peer peer (.clk(SYS_CLK), .active(active), .slow(slow),
    .lines_n({CD_N, RI_N, DSR_N, CTS_N}));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h000000, d};
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, rd[7:0], e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic pulse_done(input logic p);
    @(posedge SYS_CLK);
    RX_CHAR_DONE <= 1'b1;
    RX_CHAR_PARITY_ERR <= p;
    @(posedge SYS_CLK);
    RX_CHAR_DONE <= 1'b0;
    RX_CHAR_PARITY_ERR <= 1'b0;
  endtask

  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    SRST = 1'b1;
    {AVS_READ, AVS_WRITE, FIFO_MODE, RX_CHAR_DONE, RX_CHAR_PARITY_ERR, RX_FIFO_FULL} = 6'h00;
    {RX_TOP_PARITY_ERR, TX_CHAR_DONE, TX_IDLE, slow} = 4'h2;
    {RX_FIFO_EMPTY, AVS_ADDRESS, AVS_BYTEENABLE, active} = 13'h10F0;
    AVS_WRITEDATA = 32'h00000000;
    tick(8);
    SRST <= 1'b0;
    tick(4);
    for (i = 0; i < 16; i += 2)
      rchk("reset or unmapped", i[3:0], 8'h00);
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, mo, 8'h03);
    AVS_BYTEENABLE <= 4'hF;
    rchk("lane0 write", mo, 8'h00);
    // Receive flags, plain mode then FIFO mode
    RX_FIFO_EMPTY <= 1'b0;
    tick(2);
    rchk("ready", lc, 8'h01);
    RX_FIFO_EMPTY <= 1'b1;
    pulse_done(1'b1);
    rchk("parity", lc, 8'h04);
    rchk("parity clear", lc, 8'h00);
    {FIFO_MODE, RX_FIFO_EMPTY} <= 2'h2;
    pulse_done(1'b1);
    rchk("fifo ignores char", lc, 8'h01);
    RX_TOP_PARITY_ERR <= 1'b1;
    tick(3);
    RX_TOP_PARITY_ERR <= 1'b0;
    rchk("top parity", lc, 8'h05);
    rchk("top clear", lc, 8'h01);
    RX_FIFO_FULL <= 1'b1;
    pulse_done(1'b0);
    rchk("overrun", lc, 8'h03);
    rchk("overrun clear", lc, 8'h01);
    {RX_FIFO_FULL, RX_FIFO_EMPTY, FIFO_MODE} <= 3'h2;
    // Each line asserted then released; ring flags only its release
    for (i = 0; i < 4; i++) begin
      active <= 4'h1 << i;
      tick(6);
      chk("irq set", {7'h00, MODEM_IRQ}, {7'h00, i != 2});
      rchk("line on", mi, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i));
      tick(2);
      chk("irq clear", {7'h00, MODEM_IRQ}, 8'h00);
      slow <= i[0];
      active <= 4'h0;
      tick(6);
      rchk("line off", mi, 8'h01 << i);
    end
    rchk("quiet", mi, 8'h00);
    bus(1'b1, mo, 8'h15);
    tick(3);
    chk("loop pins", {3'h0, LOOPBACK, USER_OUTPUT_SECOND_N, USER_OUTPUT_FIRST_N, RTS_N, DTR_N}, 8'h1F);
    bus(1'b0, mi, 8'h00);
    chk("loop map a", {4'h0, rd[7:4]}, 8'h06);
    bus(1'b1, mo, 8'h1A);
    tick(3);
    bus(1'b0, mi, 8'h00);
    chk("loop map b", {4'h0, rd[7:4]}, 8'h09);
    bus(1'b1, mo, 8'h0A);
    tick(3);
    chk("normal pins", {3'h0, LOOPBACK, USER_OUTPUT_SECOND_N, USER_OUTPUT_FIRST_N, RTS_N, DTR_N}, 8'h05);
    rchk("control back", mo, 8'h0A);
    bus(1'b1, mo, 8'h00);
    tick(3);
    bus(1'b0, mi, 8'h00);
    rchk("after loop", mi, 8'h00);
    // Automatic stop on the clear-to-send line
    active <= 4'h1;
    TX_IDLE <= 1'b0;
    bus(1'b1, fe, 8'h80);
    tick(4);
    chk("run", {7'h00, TX_HALT}, 8'h00);
    active <= 4'h0;
    tick(6);
    chk("mid char", {7'h00, TX_HALT}, 8'h00);
    TX_CHAR_DONE <= 1'b1;
    tick(1);
    TX_CHAR_DONE <= 1'b0;
    tick(3);
    chk("halted", {7'h00, TX_HALT}, 8'h01);
    active <= 4'h1;
    tick(5);
    chk("resume", {7'h00, TX_HALT}, 8'h00);
    bus(1'b1, fe, 8'h00);
    TX_IDLE <= 1'b1;
    complete_run();
  end
endmodule
bind uart_line_modem_status uart_status_sva chk_i (.*);
`default_nettype wire
